// File: bench/rsm_host_model.sv
// Host model that issues single-byte register reads and writes on the register port
`default_nettype none
module rsm_host_model
(
  input wire logic core_clk_i,                   // System clock
  input wire rsm_pkg::rsm_byte_type reg_rdata_i, // Read data from the bank
  input wire logic reg_rvalid_i,                 // Read data valid pulse
  output logic [7:0] reg_addr_o,                 // Register offset
  output logic reg_wr_o,                         // Write strobe
  output rsm_pkg::rsm_byte_type reg_wdata_o,     // Write data
  output logic reg_rd_o                          // Read strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  import rsm_pkg::*;

  // ****************************************************************
  // Idle levels at time zero
  // ****************************************************************
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end

  // One-cycle write; address and data are scrambled once released,
  // so a bank that samples them late sees garbage
  task automatic reg_write(input logic [7:0] a, input rsm_byte_type d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    // Reserved status bits are always sent as zero
    reg_wdata_o <= (a == 8'h09 || a == 8'h0a) ? (d & 8'h8f) : d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : reg_write

  // One-cycle read, then a bounded wait for the valid pulse
  task automatic reg_read(input logic [7:0] a, output rsm_byte_type d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    // A missing answer hands back unknowns, which never match
    while (reg_rvalid_i !== 1'b1 && n < 4)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
  endtask : reg_read
endmodule : rsm_host_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking testbench of the regulator status and mode bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsm_pkg::*;

  // ****************************************************************
  // Signals and model state
  // ****************************************************************
  logic core_clk_i, nrst_i;
  logic [7:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, lp;
  rsm_byte_type reg_wdata, reg_rdata, rd_v;
  logic [1:0] en, soft_start_done, pg, current_limit_flag;
  logic sw1_en, sw1_fs;
  rsm_level_type sw1_lvl;
  integer fails = 0, n_compared = 0, cycles = 0, seed = 32'h2723711b;
  int fault [2];      // Model fault latch per regulator
  int cfg [2];        // Model config: 0 active, 1 low power
  int a, d;

  rsm_regbank u_rsm_regbank (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid), .ldo_enable_i(en), .ldo_soft_start_done_i(soft_start_done),
    .ldo_power_good_i(pg), .ldo_current_limit_i(current_limit_flag), .low_power_i(lp),
    .sw1_enable_o(sw1_en), .sw1_forced_switching_o(sw1_fs), .sw1_output_level_code_o(sw1_lvl));
  rsm_host_model u_rsm_host_model (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata),
    .reg_rvalid_i(reg_rvalid), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd));

  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // About 1850 cycles are needed; the ceiling leaves ample margin
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input rsm_byte_type seen, input rsm_byte_type exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Fault condition of one regulator from the live pins
  function automatic int cond(input int i);
    return en[i] & soft_start_done[i] & ~pg[i];
  endfunction : cond

  // Drive pins, let them pass the synchroniser, then latch model faults
  task automatic set_pins(input logic [8:0] v);
    @(posedge core_clk_i);
    {lp, current_limit_flag, pg, soft_start_done, en} <= v;
    repeat (5) @(posedge core_clk_i);
    #1;
    for (int i = 0; i < 2; i++)
      fault[i] = fault[i] | cond(i);
  endtask : set_pins

  // Read one status byte and compare with the model layout
  task automatic rd_status(input int i);
    rsm_byte_type e;
    e = {1'(fault[i]), 3'b000, current_limit_flag[i], en[i] & soft_start_done[i], pg[i], en[i]};
    u_rsm_host_model.reg_read(8'h09 + 8'(i), rd_v);
    check(rd_v, e);
    // Read clears the latch unless the condition still holds
    fault[i] = cond(i);
  endtask : rd_status

  // Applied switcher settings follow the config of the current state
  task automatic chk_out();
    repeat (4) @(posedge core_clk_i);
    #1;
    check({sw1_en, sw1_fs, sw1_lvl}, 8'(cfg[lp]));
  endtask : chk_out

  task automatic print_verdict();
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    nrst_i = 1'b0;
    {lp, current_limit_flag, pg, soft_start_done, en} = 9'h000;
    fault = '{0, 0};
    cfg = '{8'hf7, 8'hb7};
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    // Reset values of every register and applied outputs
    chk_out();
    u_rsm_host_model.reg_read(8'h10, rd_v);
    check(rd_v, 8'hf7);
    u_rsm_host_model.reg_read(8'h11, rd_v);
    check(rd_v, 8'hb7);
    rd_status(0);
    rd_status(1);
    set_pins(9'h100);
    chk_out();
    // Fault on both regulators, then condition removed: latched on both, then cleared on regulator 0
    set_pins(9'h00f);
    set_pins(9'h03f);
    rd_status(0);
    rd_status(0);
    rd_status(1);
    // Random pins, config writes and refused accesses
    for (int k = 0; k < 60; k++)
    begin
      set_pins(9'($random(seed)));
      rd_status(0);
      rd_status(1);
      a = 8'h10 + ($random(seed) & 1);
      d = $random(seed) & 8'hff;
      u_rsm_host_model.reg_write(8'(a), 8'(d));
      cfg[a - 8'h10] = d;
      chk_out();
      u_rsm_host_model.reg_read(8'(a), rd_v);
      check(rd_v, 8'(d));
      // Writes to status and to an unmapped offset change nothing
      u_rsm_host_model.reg_write(8'h09 + 8'(k & 1), 8'($random(seed)));
      u_rsm_host_model.reg_write(8'h12 + 8'(k & 3), 8'($random(seed)));
      u_rsm_host_model.reg_read(8'h0b + 8'(k & 3), rd_v);
      check(rd_v, 8'h00);
      rd_status(k & 1);
      u_rsm_host_model.reg_read(8'h10, rd_v);
      check(rd_v, 8'(cfg[0]));
      u_rsm_host_model.reg_read(8'h11, rd_v);
      check(rd_v, 8'(cfg[1]));
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire

// File: src/rsm_ldo_status.sv
// Status register of one linear regulator with its clear-on-read fault latch
`include "rsm_map.svh"
`default_nettype none
module rsm_ldo_status
(
  input wire logic core_clk_i,           // System clock
  input wire logic nrst_i,               // Async reset, active low
  input wire logic enable_state_i,       // Synchronised enable
  input wire logic soft_start_done_i,    // Synchronised ramp done
  input wire logic power_good_i,         // Synchronised comparator
  input wire logic current_limit_flag_i, // Synchronised current limit
  input wire logic clear_on_read_i,      // Read strobe of this register
  output rsm_pkg::rsm_byte_type status_o // Assembled status byte
);
  import rsm_pkg::*;

  // ****************************************************************
  // Fault latch
  // ****************************************************************
  logic fault_latch_r;   // Latched fault
  logic fault_latch_nxt; // Next fault value
  wire fault_set;        // Fault condition this cycle
  wire ssd_gated;        // Ramp done qualified by enable

  // Ramp done means nothing while the regulator is off
  assign ssd_gated = enable_state_i & soft_start_done_i;
  // Enabled, ramped and not good at the same time
  assign fault_set = enable_state_i & soft_start_done_i & ~power_good_i;
  // Set beats the read clear so an event in the clearing cycle is kept
  assign fault_latch_nxt = fault_set | (fault_latch_r & ~clear_on_read_i);

  // Fault flop
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fault_latch_r <= 1'b0;
    end
    else
    begin
      fault_latch_r <= fault_latch_nxt;
    end
  end

  // ****************************************************************
  // Status byte; live bits pass straight from the synchronisers
  // ****************************************************************
  assign status_o = {fault_latch_r, 3'h0, current_limit_flag_i, ssd_gated,
                     power_good_i, enable_state_i};

endmodule : rsm_ldo_status
`default_nettype wire

// File: src/rsm_map.svh
// Register offsets, field positions, reset values and timing counts of the regulator bank
`ifndef RSM_MAP_SVH
`define RSM_MAP_SVH

// ****************************************************************
// Register offsets on the register port
// ****************************************************************
`define RSM_LDO1_STS_ADDR 8'h09
`define RSM_LDO2_STS_ADDR 8'h0a
`define RSM_SW1_ACT_ADDR 8'h10
`define RSM_SW1_LPM_ADDR 8'h11

// ****************************************************************
// Field positions
// ****************************************************************
`define RSM_STS_FAULT_BIT 7
`define RSM_STS_RSVD_HI 6
`define RSM_STS_RSVD_LO 4
`define RSM_STS_CURRENT_LIMIT_FLAG_BIT 3
`define RSM_STS_SSD_BIT 2
`define RSM_STS_PGOOD_BIT 1
`define RSM_STS_ENS_BIT 0
`define RSM_CFG_EN_BIT 7
`define RSM_CFG_MODE_BIT 6
`define RSM_CFG_LEVEL_HI 5
`define RSM_CFG_LEVEL_LO 0

// ****************************************************************
// Reset values
// ****************************************************************
`define RSM_STS_RST 8'h00
`define RSM_SW1_ACT_RST 8'hf7
`define RSM_SW1_LPM_RST 8'hb7
`define RSM_LEVEL_RST 6'h37
`define RSM_RDATA_RST 8'h00

// ****************************************************************
// Timing counts
// ****************************************************************
`define RSM_SYNC_STAGES 2

`endif

// File: src/rsm_pkg.sv
// Types shared by the regulator status and mode bank
`default_nettype none
package rsm_pkg;
  // One register byte
  typedef logic [7:0] rsm_byte_type;
  // Six-bit output level code
  typedef logic [5:0] rsm_level_type;
  // Processor power state, one-hot
  typedef enum logic [1:0]
  {
    RSM_PS_ACTIVE = 2'b01,
    RSM_PS_LOWPWR = 2'b10
  } rsm_pstate_type;
endpackage : rsm_pkg
`default_nettype wire

// File: src/rsm_regbank.sv
// Regulator status and switcher mode register bank, top level
`include "rsm_map.svh"
`default_nettype none
module rsm_regbank
(
  input wire logic core_clk_i,                   // System clock, 100 MHz
  input wire logic nrst_i,                       // Async reset, active low
  input wire logic [7:0] reg_addr_i,             // Register offset
  input wire logic reg_wr_i,                     // Write strobe, one cycle
  input wire rsm_pkg::rsm_byte_type reg_wdata_i, // Write data
  input wire logic reg_rd_i,                     // Read strobe, one cycle
  output rsm_pkg::rsm_byte_type reg_rdata_o,     // Read data, next cycle
  output logic reg_rvalid_o,                     // Read data valid pulse
  input wire logic [1:0] ldo_enable_i,           // Live enable per regulator
  input wire logic [1:0] ldo_soft_start_done_i,  // Ramp finished per regulator
  input wire logic [1:0] ldo_power_good_i,       // Comparator per regulator
  input wire logic [1:0] ldo_current_limit_i,    // Current limit per regulator
  input wire logic low_power_i,                  // Processor in low-power state
  output logic sw1_enable_o,                     // Applied switcher enable
  output logic sw1_forced_switching_o,           // Applied forced-PWM mode
  output rsm_pkg::rsm_level_type sw1_output_level_code_o // Applied level code
);
  import rsm_pkg::*;

  // ****************************************************************
  // Address decode helper
  // ****************************************************************
  // True when the offset matches a register
  function automatic logic rsm_hit(input logic [7:0] addr, input logic [7:0] target);
    rsm_hit = (addr == target);
  endfunction : rsm_hit

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Analog monitors are asynchronous, so every pin passes two flops
  localparam int NSYNC = 9;  // Eight monitor bits and the power state
  wire [NSYNC-1:0] pin_raw;  // Raw pins
  logic [NSYNC-1:0] meta_r;  // First stage, read only by second stage
  logic [NSYNC-1:0] sync_r;  // Second stage, safe to use

  assign pin_raw = {low_power_i, ldo_current_limit_i, ldo_power_good_i,
                    ldo_soft_start_done_i, ldo_enable_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      // Two-flop synchroniser per pin
      always_ff @(posedge core_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= pin_raw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  wire [1:0] ens_s;   // Synchronised enables
  wire [1:0] ssd_s;   // Synchronised ramp done
  wire [1:0] pg_s;    // Synchronised power good
  wire [1:0] current_limit_flag_s;  // Synchronised current limit
  wire lowpwr_s;      // Synchronised power state
  assign ens_s = sync_r[1:0];
  assign ssd_s = sync_r[3:2];
  assign pg_s = sync_r[5:4];
  assign current_limit_flag_s = sync_r[7:6];
  assign lowpwr_s = sync_r[8];

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire hit_ldo1;  // Offset of first status register
  wire hit_ldo2;  // Offset of second status register
  wire hit_act;   // Offset of active config
  wire hit_lpm;   // Offset of low-power config
  wire [1:0] sts_rd;  // Read strobes of the status registers

  assign hit_ldo1 = rsm_hit(reg_addr_i, `RSM_LDO1_STS_ADDR);
  assign hit_ldo2 = rsm_hit(reg_addr_i, `RSM_LDO2_STS_ADDR);
  assign hit_act = rsm_hit(reg_addr_i, `RSM_SW1_ACT_ADDR);
  assign hit_lpm = rsm_hit(reg_addr_i, `RSM_SW1_LPM_ADDR);
  assign sts_rd = {reg_rd_i & hit_ldo2, reg_rd_i & hit_ldo1};

  // ****************************************************************
  // Linear regulator status registers
  // ****************************************************************
  rsm_byte_type sts [2];  // Status bytes

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ldo
      rsm_ldo_status u_sts
      (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .enable_state_i(ens_s[gi]),
        .soft_start_done_i(ssd_s[gi]),
        .power_good_i(pg_s[gi]),
        .current_limit_flag_i(current_limit_flag_s[gi]),
        .clear_on_read_i(sts_rd[gi]),
        .status_o(sts[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Switcher configuration registers
  // ****************************************************************
  rsm_byte_type act_cfg_r;  // Active-state configuration
  rsm_byte_type lpm_cfg_r;  // Low-power-state configuration
  wire act_we;              // Write to active config
  wire lpm_we;              // Write to low-power config

  // Status registers ignore writes; only the two configs take them
  assign act_we = reg_wr_i & hit_act;
  assign lpm_we = reg_wr_i & hit_lpm;

  // Config flops, reset to documented defaults
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      act_cfg_r <= `RSM_SW1_ACT_RST;
      lpm_cfg_r <= `RSM_SW1_LPM_RST;
    end
    else
    begin
      if (act_we)
      begin
        act_cfg_r <= reg_wdata_i;
      end
      if (lpm_we)
      begin
        lpm_cfg_r <= reg_wdata_i;
      end
    end
  end

  // ****************************************************************
  // Applying the configuration of the current power state
  // ****************************************************************
  rsm_pstate_type pstate;  // Current processor power state
  rsm_byte_type cfg_sel;   // Config of that state

  assign pstate = lowpwr_s ? RSM_PS_LOWPWR : RSM_PS_ACTIVE;
  assign cfg_sel = (pstate == RSM_PS_LOWPWR) ? lpm_cfg_r : act_cfg_r;

  logic sw1_enable_r;         // Applied enable
  logic sw1_forced_r;         // Applied mode
  rsm_level_type sw1_level_r; // Applied level code

  // Outputs are registered so the analog side sees glitch-free settings
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sw1_enable_r <= 1'b1;
      sw1_forced_r <= 1'b1;
      sw1_level_r <= `RSM_LEVEL_RST;
    end
    else
    begin
      sw1_enable_r <= cfg_sel[`RSM_CFG_EN_BIT];
      sw1_forced_r <= cfg_sel[`RSM_CFG_MODE_BIT];
      sw1_level_r <= cfg_sel[`RSM_CFG_LEVEL_HI:`RSM_CFG_LEVEL_LO];
    end
  end

  assign sw1_enable_o = sw1_enable_r;
  assign sw1_forced_switching_o = sw1_forced_r;
  assign sw1_output_level_code_o = sw1_level_r;

  // ****************************************************************
  // Read path
  // ****************************************************************
  rsm_byte_type rdata_nxt;  // Selected read byte
  rsm_byte_type rdata_r;    // Registered read byte
  logic rvalid_r;           // Read valid pulse

  // Unmapped offsets read as zero
  assign rdata_nxt = hit_ldo1 ? sts[0] :
                     hit_ldo2 ? sts[1] :
                     hit_act ? act_cfg_r :
                     hit_lpm ? lpm_cfg_r : `RSM_RDATA_RST;

  // Read data is captured with the pre-clear fault, so no event is lost
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_r <= `RSM_RDATA_RST;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i)
      begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // Edges since reset, saturating at three; the pin history that $past
  // sees is stale until the synchronisers have refilled after a reset
  logic [1:0] rst_age_r; // Edges since reset

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_age_r <= 2'h0;
    end
    else if (rst_age_r != 2'h3)
    begin
      rst_age_r <= rst_age_r + 2'h1;
    end
  end

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chk
      a_fault_sets: assert property (
        (ens_s[gi] && ssd_s[gi] && !pg_s[gi]) |=> sts[gi][`RSM_STS_FAULT_BIT])
        else $error("fault not latched");
      a_fault_clears: assert property (
        (sts_rd[gi] && !(ens_s[gi] && ssd_s[gi] && !pg_s[gi]))
        |=> !sts[gi][`RSM_STS_FAULT_BIT])
        else $error("fault not cleared by read");
      a_fault_holds: assert property (
        (sts[gi][`RSM_STS_FAULT_BIT] && !sts_rd[gi]) |=> sts[gi][`RSM_STS_FAULT_BIT])
        else $error("fault dropped without read");
      // Live bits against the raw pins two edges back, once the flops have refilled
      a_current_limit_flag_live: assert property (
        rst_age_r[1] |-> $past(ldo_current_limit_i[gi], 2) == sts[gi][`RSM_STS_CURRENT_LIMIT_FLAG_BIT])
        else $error("current limit not live");
      a_ssd_gated: assert property (
        rst_age_r[1] |-> sts[gi][`RSM_STS_SSD_BIT]
          == ($past(ldo_enable_i[gi], 2) && $past(ldo_soft_start_done_i[gi], 2)))
        else $error("soft start done not gated");
      a_pgood_live: assert property (
        rst_age_r[1] |-> $past(ldo_power_good_i[gi], 2) == sts[gi][`RSM_STS_PGOOD_BIT])
        else $error("power good not live");
      a_ens_live: assert property (
        rst_age_r[1] |-> $past(ldo_enable_i[gi], 2) == sts[gi][`RSM_STS_ENS_BIT])
        else $error("enable state not live");
      a_rsvd_zero: assert property (
        sts[gi][`RSM_STS_RSVD_HI:`RSM_STS_RSVD_LO] == 3'h0)
        else $error("reserved status bits nonzero");
      a_read_status: assert property (
        sts_rd[gi] |=> reg_rvalid_o && reg_rdata_o == $past(sts[gi]))
        else $error("status read lost the fault");
    end
  endgenerate

  // Register port and applied settings
  a_cfg_write: assert property (
    act_we |=> act_cfg_r == $past(reg_wdata_i))
    else $error("active config not written");
  a_lpm_write: assert property (
    lpm_we |=> lpm_cfg_r == $past(reg_wdata_i))
    else $error("low-power config not written");
  a_apply_active: assert property (
    !lowpwr_s |=> {sw1_enable_o, sw1_forced_switching_o, sw1_output_level_code_o}
      == $past(act_cfg_r))
    else $error("active config not applied");
  a_apply_lowpwr: assert property (
    lowpwr_s |=> {sw1_enable_o, sw1_forced_switching_o, sw1_output_level_code_o}
      == $past(lpm_cfg_r))
    else $error("low-power config not applied");
  a_read_data: assert property (
    (reg_rd_i && hit_act) |=> reg_rvalid_o && reg_rdata_o == $past(act_cfg_r))
    else $error("read data wrong");
  a_rd_unmapped: assert property (
    (reg_rd_i && !(hit_ldo1 || hit_ldo2 || hit_act || hit_lpm)) |=> reg_rdata_o == 8'h00)
    else $error("unmapped offset did not read zero");
  a_rdata_holds: assert property (
    !reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o))
    else $error("read port changed without a read");

  // Main scenarios that the bench is expected to reach
  c_fault_read: cover property (sts_rd[0] && sts[0][`RSM_STS_FAULT_BIT]);
  c_set_wins: cover property (sts_rd[1] && ens_s[1] && ssd_s[1] && !pg_s[1]);
  c_lowpwr_apply: cover property (lowpwr_s ##1 !lowpwr_s);
  c_cfg_write: cover property (lpm_we);

endmodule : rsm_regbank
`default_nettype wire
